//--- hdl/atc_pkg.sv
package atc_pkg;
    // analog count range and parameter limits
    localparam int COUNT_W = 10;
    localparam logic [9:0] COUNT_FULL = 10'h3e8;
    localparam int GAIN_W = 11;
    localparam logic [10:0] GAIN_MAX = 11'h3e8;
    localparam int OFFSET_W = 11;
    localparam logic signed [10:0] OFFSET_MAX = 11'sh3e7;
    localparam int THRESH_W = 16;
    localparam int VALUE_W = 24;
    localparam int CHAN_MAX = 8;
    localparam int SEL_W = 3;
    localparam logic [6:0] PERCENT_DIV = 7'h64;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_GAIN = 8'h04;
    localparam logic [7:0] ADDR_OFFSET = 8'h08;
    localparam logic [7:0] ADDR_ON_TH = 8'h0c;
    localparam logic [7:0] ADDR_OFF_TH = 8'h10;
    localparam logic [7:0] ADDR_DIFF_TH = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_SWVAL = 8'h1c;
    localparam logic [7:0] ADDR_DIFFVAL = 8'h20;
    // control fields
    localparam int CTRL_SW_SEL_LSB = 0;
    localparam int CTRL_CMP_X_LSB = 4;
    localparam int CTRL_CMP_Y_LSB = 8;
    // reset values
    localparam logic [10:0] GAIN_RST = 11'h064;
    localparam logic [31:0] CTRL_RST = 32'h0000_0100;
endpackage

//--- hdl/atc_scale.sv
`timescale 1ns/100ps
`default_nettype none
// offset then percentage gain on one count
module atc_scale (
    input wire logic [9:0] count,
    input wire logic signed [10:0] offset,
    input wire logic [10:0] gain,
    output logic signed [23:0] scaled
);
    logic signed [12:0] corrected;
    logic signed [24:0] product;
    always_comb begin
        corrected = $signed({3'h0, count}) + 13'(offset);
        product = 25'(corrected) * $signed({14'h0, gain});
        scaled = 24'(product / 25'sd100);
    end
endmodule
`default_nettype wire

//--- hdl/atc_top.sv
`timescale 1ns/100ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - threshold switch source chosen from up to eight analog channels.
// - gain is a percentage; 1000 percent multiplies by ten.
// - offset is signed, magnitude at most 999, shared by both functions.
// - switch value is (raw plus offset) times gain.
// - switch output sets when value is strictly above on threshold.
// - switch output clears when value is at or below off threshold and not above on threshold.
// - comparator adds the same offset to both inputs.
// - comparator scales both corrected inputs by the same gain.
// - comparator difference is scaled first minus scaled second.
// - comparator output high only when difference exceeds threshold, no hysteresis.
module atc_top #(
    parameter int NUM_CHAN = atc_pkg::CHAN_MAX
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [NUM_CHAN*10-1:0] ANALOG_CHANNELS,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic SWITCH_OUT,
    output logic COMPARE_OUT
);
    //////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl_reg;
    logic [10:0] gain_reg;
    logic signed [10:0] offset_reg;
    logic signed [15:0] on_threshold_reg;
    logic signed [15:0] off_threshold_reg;
    logic signed [15:0] diff_threshold_reg;
    logic switch_reg;
    logic compare_reg;
    logic signed [23:0] sw_value_reg;
    logic signed [23:0] diff_value_reg;
    logic signed [23:0] sw_value_next;
    logic signed [23:0] diff_value_next;
    logic signed [23:0] scaled_x;
    logic signed [23:0] scaled_y;
    logic [9:0] chan [NUM_CHAN];
    logic [9:0] analog_input_x;
    logic [9:0] analog_input_y;
    logic [9:0] sw_source;
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    function automatic logic [9:0] clamp_count(input logic [9:0] raw);
        clamp_count = (raw > atc_pkg::COUNT_FULL) ? atc_pkg::COUNT_FULL : raw;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // channel unpack, counts limited to full scale
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
            assign chan[gi] = clamp_count(ANALOG_CHANNELS[gi*10 +: 10]);
        end
    endgenerate

    always_comb begin
        sw_source = chan[0];
        analog_input_x = chan[0];
        analog_input_y = chan[0];
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (ctrl_reg[atc_pkg::CTRL_SW_SEL_LSB +: 3] == 3'(i)) begin
                sw_source = chan[i];
            end
            if (ctrl_reg[atc_pkg::CTRL_CMP_X_LSB +: 3] == 3'(i)) begin
                analog_input_x = chan[i];
            end
            if (ctrl_reg[atc_pkg::CTRL_CMP_Y_LSB +: 3] == 3'(i)) begin
                analog_input_y = chan[i];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // scaling: same offset and gain for every path
    logic signed [23:0] scaled_sw;
    atc_scale u_scale_sw (
        .count(sw_source),
        .offset(offset_reg),
        .gain(gain_reg),
        .scaled(scaled_sw)
    );
    atc_scale u_scale_x (
        .count(analog_input_x),
        .offset(offset_reg),
        .gain(gain_reg),
        .scaled(scaled_x)
    );
    atc_scale u_scale_y (
        .count(analog_input_y),
        .offset(offset_reg),
        .gain(gain_reg),
        .scaled(scaled_y)
    );

    always_comb begin
        sw_value_next = scaled_sw;
        diff_value_next = scaled_x - scaled_y;
    end

    //////////////////////////////////////////////////////////////////////////
    // evaluation every clock
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sw_value_reg <= '0;
            diff_value_reg <= '0;
        end else begin
            sw_value_reg <= sw_value_next;
            diff_value_reg <= diff_value_next;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            switch_reg <= 1'b0;
        end else if (sw_value_next > 24'(on_threshold_reg)) begin
            switch_reg <= 1'b1;
        end else if (sw_value_next <= 24'(off_threshold_reg)) begin
            switch_reg <= 1'b0;
        end
        // otherwise hold
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            compare_reg <= 1'b0;
        end else begin
            compare_reg <= (diff_value_next > 24'(diff_threshold_reg));
        end
    end

    assign SWITCH_OUT = switch_reg;
    assign COMPARE_OUT = compare_reg;

    //////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states
    assign PREADY = 1'b1;
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && !PWRITE;

    always_comb begin
        unique case (PADDR)
            atc_pkg::ADDR_CTRL, atc_pkg::ADDR_GAIN, atc_pkg::ADDR_OFFSET,
            atc_pkg::ADDR_ON_TH, atc_pkg::ADDR_OFF_TH, atc_pkg::ADDR_DIFF_TH,
            atc_pkg::ADDR_STATUS, atc_pkg::ADDR_SWVAL, atc_pkg::ADDR_DIFFVAL:
                addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign PSLVERR = PSEL && PENABLE && !addr_ok;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_reg <= atc_pkg::CTRL_RST;
            gain_reg <= atc_pkg::GAIN_RST;
            offset_reg <= '0;
            on_threshold_reg <= '0;
            off_threshold_reg <= '0;
            diff_threshold_reg <= '0;
        end else if (wr_en) begin
            unique case (PADDR)
                atc_pkg::ADDR_CTRL: ctrl_reg <= PWDATA & 32'h0000_0777;
                atc_pkg::ADDR_GAIN: begin
                    // gain limited to 0..1000 percent
                    gain_reg <= (PWDATA[10:0] > atc_pkg::GAIN_MAX) ? atc_pkg::GAIN_MAX
                                                                  : PWDATA[10:0];
                end
                atc_pkg::ADDR_OFFSET: begin
                    if ($signed(PWDATA) > 32'(atc_pkg::OFFSET_MAX)) begin
                        offset_reg <= atc_pkg::OFFSET_MAX;
                    end else if ($signed(PWDATA) < -32'(atc_pkg::OFFSET_MAX)) begin
                        offset_reg <= -atc_pkg::OFFSET_MAX;
                    end else begin
                        offset_reg <= PWDATA[10:0];
                    end
                end
                atc_pkg::ADDR_ON_TH: on_threshold_reg <= PWDATA[15:0];
                atc_pkg::ADDR_OFF_TH: off_threshold_reg <= PWDATA[15:0];
                atc_pkg::ADDR_DIFF_TH: diff_threshold_reg <= PWDATA[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PRDATA <= '0;
        end else if (rd_en && !PENABLE) begin
            unique case (PADDR)
                atc_pkg::ADDR_CTRL: PRDATA <= ctrl_reg;
                atc_pkg::ADDR_GAIN: PRDATA <= {21'h0, gain_reg};
                atc_pkg::ADDR_OFFSET: PRDATA <= 32'(offset_reg);
                atc_pkg::ADDR_ON_TH: PRDATA <= 32'(on_threshold_reg);
                atc_pkg::ADDR_OFF_TH: PRDATA <= 32'(off_threshold_reg);
                atc_pkg::ADDR_DIFF_TH: PRDATA <= 32'(diff_threshold_reg);
                atc_pkg::ADDR_STATUS: PRDATA <= {30'h0, compare_reg, switch_reg};
                atc_pkg::ADDR_SWVAL: PRDATA <= 32'(sw_value_reg);
                atc_pkg::ADDR_DIFFVAL: PRDATA <= 32'(diff_value_reg);
                default: PRDATA <= '0;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    set_above_on_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (sw_value_next > 24'(on_threshold_reg)) |=> SWITCH_OUT)
        else $error("switch not set above on threshold");
    clear_below_off_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (sw_value_next <= 24'(off_threshold_reg) && sw_value_next <= 24'(on_threshold_reg))
        |=> !SWITCH_OUT)
        else $error("switch not cleared at off threshold");
    hold_band_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (sw_value_next > 24'(off_threshold_reg) && sw_value_next <= 24'(on_threshold_reg))
        |=> (SWITCH_OUT == $past(SWITCH_OUT)))
        else $error("switch changed inside hysteresis band");
    compare_out_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        COMPARE_OUT == (diff_value_reg > 24'(diff_threshold_reg)) || $changed(diff_threshold_reg))
        else $error("comparator output wrong");
    diff_order_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        $past(RESET_N) |-> (diff_value_reg == $past(scaled_x) - $past(scaled_y)))
        else $error("difference sign wrong");
    offset_limit_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        offset_reg <= atc_pkg::OFFSET_MAX && offset_reg >= -atc_pkg::OFFSET_MAX)
        else $error("offset outside limit");
    gain_limit_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        gain_reg <= atc_pkg::GAIN_MAX)
        else $error("gain outside limit");
    equal_inputs_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (analog_input_x == analog_input_y) |-> (scaled_x == scaled_y))
        else $error("comparator paths not scaled alike");
    src_clamp_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        sw_source <= atc_pkg::COUNT_FULL)
        else $error("switch source above full scale");
    cmp_clamp_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        analog_input_x <= atc_pkg::COUNT_FULL && analog_input_y <= atc_pkg::COUNT_FULL)
        else $error("comparator input above full scale");
    src_select_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (ctrl_reg[2:0] < NUM_CHAN) |-> (sw_source == chan[ctrl_reg[2:0]]))
        else $error("switch source channel wrong");
    x_select_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (ctrl_reg[6:4] < NUM_CHAN) |-> (analog_input_x == chan[ctrl_reg[6:4]]))
        else $error("comparator first channel wrong");
    y_select_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (ctrl_reg[10:8] < NUM_CHAN) |-> (analog_input_y == chan[ctrl_reg[10:8]]))
        else $error("comparator second channel wrong");
    gain_ten_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (gain_reg == atc_pkg::GAIN_MAX) |->
        (scaled_sw == 24'(25'($signed({3'h0, sw_source}) + 13'(offset_reg)) * 25'sd10)))
        else $error("full gain is not times ten");
    zero_gain_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (gain_reg == 11'h000) |-> (scaled_sw == 24'sd0 && scaled_x == 24'sd0))
        else $error("zero gain gives nonzero value");
    unity_sw_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (gain_reg == atc_pkg::GAIN_RST) |->
        (scaled_sw == 24'($signed({3'h0, sw_source}) + 13'(offset_reg))))
        else $error("switch offset not added");
    unity_x_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (gain_reg == atc_pkg::GAIN_RST) |->
        (scaled_x == 24'($signed({3'h0, analog_input_x}) + 13'(offset_reg))))
        else $error("comparator offset not added");
    same_gain_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (gain_reg == atc_pkg::GAIN_MAX) |->
        (scaled_x - scaled_y == 24'(25'd10 * (25'(analog_input_x) - 25'(analog_input_y)))))
        else $error("comparator paths scaled differently");
    sw_track_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        $past(RESET_N) |-> (sw_value_reg == $past(scaled_sw)))
        else $error("switch value not updated each cycle");
    sw_range_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        sw_value_reg <= 24'sd19990 && sw_value_reg >= -24'sd9990)
        else $error("switch value overflow");
    diff_range_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        diff_value_reg <= 24'sd10001 && diff_value_reg >= -24'sd10001)
        else $error("difference overflow");
    sw_rise_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        $rose(SWITCH_OUT) |-> (sw_value_reg > 24'($past(on_threshold_reg))))
        else $error("switch set without exceeding on threshold");
    sw_fall_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        $fell(SWITCH_OUT) |-> (sw_value_reg <= 24'($past(off_threshold_reg))))
        else $error("switch cleared above off threshold");
    cmp_rise_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        $rose(COMPARE_OUT) |-> (diff_value_reg > 24'($past(diff_threshold_reg))))
        else $error("comparator set at or below threshold");
    cmp_low_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (!COMPARE_OUT && $past(RESET_N)) |->
        (diff_value_reg <= 24'($past(diff_threshold_reg))))
        else $error("comparator low above threshold");
    gain_write_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (wr_en && PADDR == atc_pkg::ADDR_GAIN && PWDATA[10:0] <= atc_pkg::GAIN_MAX)
        |=> (gain_reg == 11'($past(PWDATA))))
        else $error("gain write lost");
    offset_write_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (wr_en && PADDR == atc_pkg::ADDR_OFFSET && $signed(PWDATA) <= 32'(atc_pkg::OFFSET_MAX)
        && $signed(PWDATA) >= -32'(atc_pkg::OFFSET_MAX)) |=> (offset_reg == 11'($past(PWDATA))))
        else $error("offset write lost");
    offset_high_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (wr_en && PADDR == atc_pkg::ADDR_OFFSET && $signed(PWDATA) > 32'(atc_pkg::OFFSET_MAX))
        |=> (offset_reg == atc_pkg::OFFSET_MAX))
        else $error("offset not clamped high");
    on_write_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (wr_en && PADDR == atc_pkg::ADDR_ON_TH) |=> (on_threshold_reg == 16'($past(PWDATA))))
        else $error("on threshold write lost");
    off_write_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (wr_en && PADDR == atc_pkg::ADDR_OFF_TH) |=> (off_threshold_reg == 16'($past(PWDATA))))
        else $error("off threshold write lost");
    dth_write_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (wr_en && PADDR == atc_pkg::ADDR_DIFF_TH)
        |=> (diff_threshold_reg == 16'($past(PWDATA))))
        else $error("difference threshold write lost");
    status_read_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (rd_en && !PENABLE && PADDR == atc_pkg::ADDR_STATUS)
        |=> (PRDATA == {30'h0, $past(compare_reg), $past(switch_reg)}))
        else $error("status read wrong");
    swval_read_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (rd_en && !PENABLE && PADDR == atc_pkg::ADDR_SWVAL)
        |=> (PRDATA == 32'($past(sw_value_reg))))
        else $error("switch value read wrong");
endmodule
`default_nettype wire

//--- sim/atc_chan_model.sv
`timescale 1ns/100ps
`default_nettype none
// analog front end: unsigned counts 0..1000, changed just after a clock edge
module atc_chan_model #(
    parameter int NUM_CHAN = 8
) (
    input wire logic CLK,
    output logic [NUM_CHAN*10-1:0] ANALOG_CHANNELS
);
    initial ANALOG_CHANNELS = '0;
    task automatic set_chan(input int idx, input logic [9:0] val);
        @(posedge CLK);
        ANALOG_CHANNELS[idx*10+:10] <= val;
    endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [79:0] chans;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sw_out;
    logic cmp_out;
    logic [31:0] rd;
    logic er;
    int n_mismatch = 0;
    int tests_run = 0;
    logic [7:0] rst_addr [7];
    logic [31:0] rst_exp [7];
    int sw_in [6];
    logic sw_exp [6];

    always #20 clk = ~clk;

    atc_top u_dut (.CLK(clk), .RESET_N(reset_n), .ANALOG_CHANNELS(chans), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SWITCH_OUT(sw_out),
        .COMPARE_OUT(cmp_out));
    atc_chan_model u_model (.CLK(clk), .ANALOG_CHANNELS(chans));

    //////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] d, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, rd, er);
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, rd, er);
        check(name, rd, exp);
    endtask

    task automatic eval_wait;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // offset, percentage gain, truncation toward zero
    function automatic int scale(int c, int off, int g);
        return (c + off) * g / 100;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    initial begin
        rst_addr = '{atc_pkg::ADDR_CTRL, atc_pkg::ADDR_GAIN, atc_pkg::ADDR_OFFSET,
            atc_pkg::ADDR_ON_TH, atc_pkg::ADDR_OFF_TH, atc_pkg::ADDR_DIFF_TH,
            atc_pkg::ADDR_STATUS};
        rst_exp = '{32'h0000_0100, 32'h0000_0064, 0, 0, 0, 0, 0};
        sw_in = '{130, 141, 140, 121, 120, 140};
        sw_exp = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++) rchk("reset value", rst_addr[i], rst_exp[i]);
        rchk("unmapped read", 8'h24, 32'h0000_0000);
        check("unmapped error", {31'h0, er}, 32'h0000_0001);
        wr(atc_pkg::ADDR_GAIN, 32'h0000_05dc);
        rchk("gain clamp", atc_pkg::ADDR_GAIN, 32'h0000_03e8);
        wr(atc_pkg::ADDR_OFFSET, 32'h0000_07d0);
        rchk("offset clamp high", atc_pkg::ADDR_OFFSET, 32'h0000_03e7);
        wr(atc_pkg::ADDR_OFFSET, 32'hffff_f830);
        rchk("offset clamp low", atc_pkg::ADDR_OFFSET, 32'hffff_fc19);
        // switch on channel 2, comparator on channels 3 and 5
        wr(atc_pkg::ADDR_CTRL, 32'h0000_0532);
        wr(atc_pkg::ADDR_OFFSET, 32'hffff_ff9c);
        wr(atc_pkg::ADDR_ON_TH, 32'h0000_0190);
        wr(atc_pkg::ADDR_OFF_TH, 32'h0000_00c8);
        for (int i = 0; i < 6; i++) begin
            u_model.set_chan(2, sw_in[i][9:0]);
            eval_wait();
            check("switch out", {31'h0, sw_out}, {31'h0, sw_exp[i]});
            rchk("switch value", atc_pkg::ADDR_SWVAL, scale(sw_in[i], -100, 1000));
        end
        wr(atc_pkg::ADDR_GAIN, 32'h0000_0021);
        wr(atc_pkg::ADDR_DIFF_TH, 32'h0000_0020);
        u_model.set_chan(3, 10'h096);
        u_model.set_chan(5, 10'h032);
        eval_wait();
        rchk("diff value", atc_pkg::ADDR_DIFFVAL,
             scale(150, -100, 33) - scale(50, -100, 33));
        check("compare at threshold", {31'h0, cmp_out}, 32'h0000_0000);
        wr(atc_pkg::ADDR_DIFF_TH, 32'h0000_001f);
        eval_wait();
        check("compare above", {31'h0, cmp_out}, 32'h0000_0001);
        rchk("status", atc_pkg::ADDR_STATUS, 32'h0000_0002);
        u_model.set_chan(3, 10'h032);
        u_model.set_chan(5, 10'h096);
        eval_wait();
        check("compare negative", {31'h0, cmp_out}, 32'h0000_0000);
        wr(atc_pkg::ADDR_DIFF_TH, 32'h0000_ffdf);
        eval_wait();
        check("compare signed th", {31'h0, cmp_out}, 32'h0000_0001);
        end_sim();
    end

    initial begin
        #(40 * 20000);
        n_mismatch++;
        end_sim();
    end
endmodule
`default_nettype wire
